// file: hw/receiver_control_tuner_cic.sv
// Purpose: per-path settings with epoch apply, telemetry over serial, tuner and CIC
// Assumes: all pin inputs asynchronous to clk; Avalon-MM master on clk
// Notes: the DSP path takes lane 0 of each input word group as its sample
// Function
// - five settings per path: enable, frequency, decimation, accumulation, tag
// - settings received are applied together on the epoch pulse
// - two serial ports at 115200 baud, one per polarization, both tunings
// - each telemetry update carries status of the two paths (both tunings) of its polarization
// - telemetry reports whether the upstream sample clock is present
// - telemetry reports whether the upstream word marker is present
// - telemetry reports the last sampled in-band signalling bits
// - counters test mode sets a counting error flag, else it reads zero
// - lane counters test mode reports one error bit per lane
// - telemetry echoes enable, frequency, decimation, accumulation and tag
// - the tag is carried unchanged into the output stream
// - the tuner selects a narrow swath from the input band
// - tuning frequency is 10-bit unsigned, step is input word rate over 1024
// - decimation ratio is two times two to the decimation code
// - six bandwidth modes are selected by the decimation code
// - accumulation count zero disables detection; nonzero sets out_detect at each dump
// - eighth-order CIC filter with programmable decimation, adds and delays only
// - CIC decimation is 2, 4, 8, 16, 32 or 64
// - CIC takes 16-bit input and keeps 64-bit registers
`default_nettype none
module receiver_control_tuner_cic
  import receiver_pkg::*;
#(
  parameter logic [7:0] BAUD_CYC = BAUD_DIV
) (
  input wire logic clk,
  input wire logic srst,
  input wire av_req_t av_req,
  output var av_rsp_t av_rsp,
  input wire lanes_t [NUM_POL-1:0] beamforming_unit_lanes,
  input wire logic [NUM_POL-1:0] beamforming_unit_valid,
  input wire logic [NUM_POL-1:0] beamforming_unit_clk_mon,
  input wire logic [NUM_POL-1:0] beamforming_unit_marker,
  input wire logic epoch_pulse,
  input wire logic [NUM_POL-1:0] uart_rx,
  output var logic [NUM_POL-1:0] uart_tx,
  output var logic [NUM_PATHS-1:0][1:0][CIC_W-1:0] out_sample,
  output var logic [NUM_PATHS-1:0] out_valid,
  output var logic [NUM_PATHS-1:0][63:0] out_tag,
  output var logic [NUM_PATHS-1:0] out_detect
);

  // ==========================================================
  // state
  typedef struct packed {
    lanes_t [NUM_POL-1:0] lanes_m, lanes_s;
    logic [NUM_POL-1:0] valid_m, valid_s, cmon_m, cmon_s, cmon_d, mark_m, mark_s, mark_d;
    logic epoch_m, epoch_s, epoch_d;
    logic [NUM_POL-1:0][6:0] clk_to, mark_to;
    logic [NUM_POL-1:0][3:0] inband;
    logic [NUM_POL-1:0][NUM_LANES-1:0][23:0] prev;
    logic [NUM_POL-1:0] have_prev, cnt_err;
    logic [NUM_POL-1:0][NUM_LANES-1:0] lane_err;
    cfg_t [NUM_PATHS-1:0] pend, act;
    logic [NUM_PATHS-1:0][9:0] phase;
    logic [NUM_PATHS-1:0][5:0] dec_cnt;
    logic [NUM_PATHS-1:0][1:0][CIC_ORDER-1:0][CIC_W-1:0] integ, dly;
    logic [NUM_PATHS-1:0][1:0][CIC_W-1:0] out_sample;
    logic [NUM_PATHS-1:0] out_valid, out_detect;
    logic [NUM_PATHS-1:0][63:0] out_tag;
    av_rsp_t rsp;
    logic [NUM_POL-1:0][7:0] u_baud, r_cnt, r_sh, r_addr;
    logic [NUM_POL-1:0][3:0] u_bit, r_bit;
    logic [NUM_POL-1:0][4:0] u_byte;
    logic [NUM_POL-1:0][9:0] u_shift;
    logic [NUM_POL-1:0][2*$bits(telem_t)-1:0] u_snap;
    logic [NUM_POL-1:0] u_tx, rx_m, rx_s, r_busy;
    logic [NUM_POL-1:0][2:0] r_idx;
    logic [NUM_POL-1:0][31:0] r_data;
  } st_t;

  st_t st;
  st_t next_st;

  // ==========================================================
  // helpers
  function automatic logic [31:0] ctrl_word(cfg_t c);
    ctrl_word = '0;
    ctrl_word[CTRL_EN_BIT] = c.enable;
    ctrl_word[CTRL_DECI_LSB +: 3] = c.deci;
    ctrl_word[CTRL_FREQ_LSB +: 10] = c.freq;
  endfunction : ctrl_word

  // shared by the bus and the serial command path
  function automatic cfg_t reg_write(cfg_t c, logic [4:0] off, logic [31:0] wd);
    reg_write = c;
    if (off == OFF_CTRL) begin
      reg_write.enable = wd[CTRL_EN_BIT];
      reg_write.deci = wd[CTRL_DECI_LSB +: 3];
      reg_write.freq = wd[CTRL_FREQ_LSB +: 10];
    end else if (off == OFF_ACCUM) begin
      reg_write.accum = wd[11:0];
    end else if (off == OFF_TAG_LO) begin
      reg_write.tag[31:0] = wd;
    end else if (off == OFF_TAG_HI) begin
      reg_write.tag[63:32] = wd;
    end
  endfunction : reg_write

  function automatic telem_t telem(st_t s, int p);
    int pol;
    pol = p / TUNINGS;
    telem = '0;
    telem.clk_present = (s.clk_to[pol] != '0);
    telem.sync_present = (s.mark_to[pol] != '0);
    telem.inband = s.inband[pol];
    telem.cnt_err = s.cnt_err[pol];
    telem.lane_err = s.lane_err[pol];
    telem.cfg = s.act[p];
  endfunction : telem

  function automatic logic [15:0] sine(logic [5:0] ph);
    logic [4:0] k;
    logic [15:0] v;
    k = ph[4] ? 5'(5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
    v = k[4] ? SIN_PEAK : SIN_LUT[k[3:0]];
    sine = ph[5] ? 16'(-v) : v;
  endfunction : sine

  function automatic logic [23:0] count_of(sample_t w);
    count_of = {w.i, w.q};
  endfunction : count_of

  // ==========================================================
  // next state
  always_comb begin : next_state
    int pol;
    int k;
    logic [23:0] expect_cnt;
    logic signed [15:0] cs;
    logic signed [15:0] sn;
    logic signed [28:0] mi;
    logic signed [28:0] mq;
    logic [1:0][CIC_W-1:0] xin;
    logic [CIC_ORDER-1:0][CIC_W-1:0] src;
    logic [CIC_W-1:0] y;
    logic [2:0] d;
    logic [5:0] last;
    logic [2:0] mode;
    logic [1:0] sel;
    logic [4:0] off;
    logic [31:0] rd;
    telem_t t;
    pol = 0;
    k = 0;
    expect_cnt = '0;
    cs = '0;
    sn = '0;
    mi = '0;
    mq = '0;
    xin = '0;
    src = '0;
    y = '0;
    d = '0;
    last = '0;
    mode = '0;
    sel = av_req.address[6:5];
    off = av_req.address[4:0];
    rd = '0;
    t = telem(st, int'(sel));
    next_st = st;

    // pin synchronisers
    next_st.lanes_m = beamforming_unit_lanes;
    next_st.lanes_s = st.lanes_m;
    next_st.valid_m = beamforming_unit_valid;
    next_st.valid_s = st.valid_m;
    next_st.cmon_m = beamforming_unit_clk_mon;
    next_st.cmon_s = st.cmon_m;
    next_st.cmon_d = st.cmon_s;
    next_st.mark_m = beamforming_unit_marker;
    next_st.mark_s = st.mark_m;
    next_st.mark_d = st.mark_s;
    next_st.epoch_m = epoch_pulse;
    next_st.epoch_s = st.epoch_m;
    next_st.epoch_d = st.epoch_s;
    next_st.rx_m = uart_rx;
    next_st.rx_s = st.rx_m;

    // ========================================================
    // input link health and test-mode checks
    for (int p = 0; p < NUM_POL; p++) begin
      if (st.cmon_s[p] != st.cmon_d[p]) begin
        next_st.clk_to[p] = PRESENT_CYC;
      end else if (st.clk_to[p] != '0) begin
        next_st.clk_to[p] = st.clk_to[p] - 7'h01;
      end
      if (st.mark_s[p] != st.mark_d[p]) begin
        next_st.mark_to[p] = PRESENT_CYC;
      end else if (st.mark_to[p] != '0) begin
        next_st.mark_to[p] = st.mark_to[p] - 7'h01;
      end
      // b3 carries the time code, so only b2..b0 select the test mode
      mode = st.lanes_s[p][0].inband[2:0];
      if (mode != MODE_COUNTERS) begin
        next_st.cnt_err[p] = 1'b0;
      end
      if (mode != MODE_LANE_COUNTERS) begin
        next_st.lane_err[p] = '0;
      end
      if (mode != MODE_COUNTERS && mode != MODE_LANE_COUNTERS) begin
        next_st.have_prev[p] = 1'b0;
      end
      if (st.valid_s[p]) begin
        next_st.inband[p] = st.lanes_s[p][0].inband;
        next_st.have_prev[p] = 1'b1;
        expect_cnt = st.have_prev[p] ? 24'(st.prev[p][0] + 24'(NUM_LANES))
                                     : count_of(st.lanes_s[p][0]);
        for (int l = 0; l < NUM_LANES; l++) begin
          next_st.prev[p][l] = count_of(st.lanes_s[p][l]);
          if (mode == MODE_COUNTERS && count_of(st.lanes_s[p][l]) != 24'(expect_cnt + 24'(l))) begin
            next_st.cnt_err[p] = 1'b1;
          end
          if (mode == MODE_LANE_COUNTERS && st.have_prev[p] &&
              count_of(st.lanes_s[p][l]) != 24'(st.prev[p][l] + 24'h000001)) begin
            next_st.lane_err[p][l] = 1'b1;
          end
        end
      end
    end

    // ========================================================
    // epoch: all pending settings become active at once
    if (st.epoch_s && !st.epoch_d) begin
      next_st.act = st.pend;
    end

    // ========================================================
    // tuner and CIC per path
    for (int p = 0; p < NUM_PATHS; p++) begin
      pol = p / TUNINGS;
      next_st.out_valid[p] = 1'b0;
      // codes above five are clamped to the narrowest mode
      d = (st.act[p].deci > DECI_MAX) ? DECI_MAX : st.act[p].deci;
      last = 6'(7'(7'h02 << d) - 7'h01);
      if (!st.act[p].enable) begin
        next_st.phase[p] = '0;
        next_st.dec_cnt[p] = '0;
        next_st.integ[p] = '0;
        next_st.dly[p] = '0;
      end else if (st.valid_s[pol]) begin
        next_st.phase[p] = st.phase[p] + st.act[p].freq;
        sn = sine(st.phase[p][9:4]);
        cs = sine(6'(st.phase[p][9:4] + 6'h10));
        mi = $signed(st.lanes_s[pol][0].i) * cs + $signed(st.lanes_s[pol][0].q) * sn;
        mq = $signed(st.lanes_s[pol][0].q) * cs - $signed(st.lanes_s[pol][0].i) * sn;
        xin[0] = {{(CIC_W - MIX_W){mi[27]}}, mi[27:12]};
        xin[1] = {{(CIC_W - MIX_W){mq[27]}}, mq[27:12]};
        for (int c = 0; c < 2; c++) begin
          src = {st.integ[p][c][CIC_ORDER-2:0], xin[c]};
          for (int s = 0; s < CIC_ORDER; s++) begin
            next_st.integ[p][c][s] = st.integ[p][c][s] + src[s];
          end
        end
        // >= keeps a shortened ratio after an epoch from wrapping the count
        if (st.dec_cnt[p] >= last) begin
          next_st.dec_cnt[p] = '0;
          for (int c = 0; c < 2; c++) begin
            y = st.integ[p][c][CIC_ORDER-1];
            for (int s = 0; s < CIC_ORDER; s++) begin
              next_st.dly[p][c][s] = y;
              y = y - st.dly[p][c][s];
            end
            next_st.out_sample[p][c] = y;
          end
          next_st.out_valid[p] = 1'b1;
          next_st.out_tag[p] = st.act[p].tag;
          next_st.out_detect[p] = (st.act[p].accum != '0);
        end else begin
          next_st.dec_cnt[p] = st.dec_cnt[p] + 6'h01;
        end
      end
    end

    // ========================================================
    // Avalon-MM slave: one wait cycle, then the answer
    if (!av_req.address[7]) begin
      if (off == OFF_CTRL) begin
        rd = ctrl_word(st.pend[sel]);
      end else if (off == OFF_ACCUM) begin
        rd = 32'(st.pend[sel].accum);
      end else if (off == OFF_TAG_LO) begin
        rd = st.pend[sel].tag[31:0];
      end else if (off == OFF_TAG_HI) begin
        rd = st.pend[sel].tag[63:32];
      end else if (off == OFF_ACT_CTRL) begin
        rd = ctrl_word(st.act[sel]);
      end else if (off == OFF_ACT_ACCUM) begin
        rd = 32'(st.act[sel].accum);
      end else if (off == OFF_STATUS) begin
        rd = 32'({t.lane_err, t.cnt_err, t.inband, t.sync_present, t.clk_present});
      end
    end
    if ((av_req.read || av_req.write) && st.rsp.waitrequest) begin
      next_st.rsp.waitrequest = 1'b0;
      next_st.rsp.readdata = av_req.read ? rd : '0;
    end else begin
      next_st.rsp.waitrequest = 1'b1;
    end
    if (av_req.write && !st.rsp.waitrequest && !av_req.address[7]) begin
      next_st.pend[sel] = reg_write(st.pend[sel], off, av_req.writedata);
    end

    // ========================================================
    // serial ports, 8N1; port u serves paths 2u and 2u+1
    for (int u = 0; u < NUM_POL; u++) begin
      // telemetry: sync byte then a snapshot of both tunings
      if (st.u_baud[u] != '0) begin
        next_st.u_baud[u] = st.u_baud[u] - 8'h01;
      end else if (st.u_bit[u] != '0) begin
        next_st.u_tx[u] = st.u_shift[u][0];
        next_st.u_shift[u] = {1'b1, st.u_shift[u][9:1]};
        next_st.u_bit[u] = st.u_bit[u] - 4'h1;
        next_st.u_baud[u] = BAUD_CYC - 8'h01;
      end else begin
        if (st.u_byte[u] == '0) begin
          next_st.u_snap[u] = {telem(st, TUNINGS * u + 1), telem(st, TUNINGS * u)};
          next_st.u_shift[u] = {1'b1, FRAME_SYNC, 1'b0};
        end else begin
          k = int'(st.u_byte[u]) - 1;
          next_st.u_shift[u] = {1'b1, st.u_snap[u][8 * k +: 8], 1'b0};
        end
        next_st.u_bit[u] = UART_FRAME_BITS;
        next_st.u_byte[u] = (st.u_byte[u] == FRAME_BYTES - 5'h01) ? '0 : st.u_byte[u] + 5'h01;
      end
      // commands: address byte then four data bytes, low byte first;
      // no resync timeout, so a lost byte shifts the frame until reset
      if (!st.r_busy[u]) begin
        if (!st.rx_s[u]) begin
          next_st.r_busy[u] = 1'b1;
          next_st.r_cnt[u] = BAUD_CYC >> 1;
          next_st.r_bit[u] = '0;
        end
      end else if (st.r_cnt[u] != '0) begin
        next_st.r_cnt[u] = st.r_cnt[u] - 8'h01;
      end else begin
        next_st.r_cnt[u] = BAUD_CYC - 8'h01;
        if (st.r_bit[u] == '0) begin
          next_st.r_busy[u] = !st.rx_s[u];
          next_st.r_bit[u] = 4'h1;
        end else if (st.r_bit[u] < RX_STOP_BIT) begin
          next_st.r_sh[u] = {st.rx_s[u], st.r_sh[u][7:1]};
          next_st.r_bit[u] = st.r_bit[u] + 4'h1;
        end else begin
          next_st.r_busy[u] = 1'b0;
          if (st.rx_s[u]) begin
            if (st.r_idx[u] == '0) begin
              next_st.r_addr[u] = st.r_sh[u];
            end else begin
              k = int'(st.r_idx[u]) - 1;
              next_st.r_data[u][8 * k +: 8] = st.r_sh[u];
            end
            if (st.r_idx[u] == CMD_BYTES - 3'h1) begin
              next_st.r_idx[u] = '0;
              if (!st.r_addr[u][7]) begin
                k = TUNINGS * u + int'(st.r_addr[u][5]);
                next_st.pend[k] = reg_write(next_st.pend[k], st.r_addr[u][4:0],
                                            {st.r_sh[u], st.r_data[u][23:0]});
              end
            end else begin
              next_st.r_idx[u] = st.r_idx[u] + 3'h1;
            end
          end
        end
      end
    end
  end : next_state

  // ==========================================================
  // registers
  always_ff @(posedge clk) begin : regs
    if (srst) begin
      st <= '0;
      st.pend <= {NUM_PATHS{CFG_RST}};
      st.act <= {NUM_PATHS{CFG_RST}};
      st.rsp.waitrequest <= WAIT_RST;
      st.u_tx <= {NUM_POL{TX_IDLE}};
    end else begin
      st <= next_st;
    end
  end : regs

  assign av_rsp = st.rsp;
  assign uart_tx = st.u_tx;
  assign out_sample = st.out_sample;
  assign out_valid = st.out_valid;
  assign out_tag = st.out_tag;
  assign out_detect = st.out_detect;

endmodule : receiver_control_tuner_cic
`default_nettype wire

// file: include/receiver_pkg.sv
// Purpose: shared constants and types of the receiver control, tuner and CIC block
// Assumes: 20 MHz core clock; four paths (two polarizations times two tunings)
// Notes: register byte address = path * 0x20 + offset, address bit 7 clear
`default_nettype none
package receiver_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam logic [7:0] BAUD_DIV = 8'((CLK_HZ + BAUD_HZ / 2) / BAUD_HZ);
  localparam int PRESENT_NS = 3200;
  localparam logic [6:0] PRESENT_CYC = 7'(PRESENT_NS / (1_000_000_000 / CLK_HZ));
  // ==========================================================
  // structure
  localparam int NUM_PATHS = 4;
  localparam int NUM_POL = 2;
  localparam int TUNINGS = 2;
  localparam int NUM_LANES = 4;
  localparam int CIC_ORDER = 8;
  localparam int CIC_W = 64;
  localparam int MIX_W = 16;
  localparam logic [2:0] DECI_MAX = 3'h5;
  localparam logic [2:0] MODE_COUNTERS = 3'h2;
  localparam logic [2:0] MODE_LANE_COUNTERS = 3'h4;
  // ==========================================================
  // serial framing
  localparam logic [4:0] FRAME_BYTES = 5'h1B;
  localparam logic [7:0] FRAME_SYNC = 8'h5A;
  localparam logic [3:0] UART_FRAME_BITS = 4'hA;
  localparam logic [3:0] RX_STOP_BIT = 4'h9;
  localparam logic [2:0] CMD_BYTES = 3'h5;
  // ==========================================================
  // register map
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_ACCUM = 5'h04;
  localparam logic [4:0] OFF_TAG_LO = 5'h08;
  localparam logic [4:0] OFF_TAG_HI = 5'h0C;
  localparam logic [4:0] OFF_ACT_CTRL = 5'h10;
  localparam logic [4:0] OFF_ACT_ACCUM = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DECI_LSB = 4;
  localparam int CTRL_FREQ_LSB = 16;
  localparam logic WAIT_RST = 1'b1;
  localparam logic TX_IDLE = 1'b1;
  // ==========================================================
  // types
  typedef struct packed {
    logic enable;
    logic [2:0] deci;
    logic [9:0] freq;
    logic [11:0] accum;
    logic [63:0] tag;
  } cfg_t;
  localparam cfg_t CFG_RST = '0;
  typedef struct packed {
    logic [3:0] inband;
    logic [11:0] i;
    logic [11:0] q;
  } sample_t;
  typedef sample_t [NUM_LANES-1:0] lanes_t;
  typedef struct packed {
    logic [2:0] pad;
    logic clk_present;
    logic sync_present;
    logic [3:0] inband;
    logic cnt_err;
    logic [3:0] lane_err;
    cfg_t cfg;
  } telem_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } av_req_t;
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } av_rsp_t;
  // quarter-wave sine, full scale 0x7FFF, 16 steps per quadrant
  localparam logic [15:0][15:0] SIN_LUT = {16'h7F62, 16'h7D8A, 16'h7A7C, 16'h7641,
    16'h70E2, 16'h6A6D, 16'h62F1, 16'h5A82, 16'h5133, 16'h471C, 16'h3C56, 16'h30FB,
    16'h2528, 16'h18F9, 16'h0C8C, 16'h0000};
  localparam logic [15:0] SIN_PEAK = 16'h7FFF;
endpackage : receiver_pkg
`default_nettype wire

// file: verification/receiver_control_tuner_cic_checker.sv
// Purpose: port-level checks of the receiver control, tuner and CIC block
// Assumes: one clock domain, srst synchronous active high
// Notes: bound to every instance of the block
`default_nettype none
module receiver_checker
  import receiver_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire av_req_t av_req,
  input wire av_rsp_t av_rsp,
  input wire logic [NUM_POL-1:0] uart_tx,
  input wire logic [NUM_PATHS-1:0][1:0][CIC_W-1:0] out_sample,
  input wire logic [NUM_PATHS-1:0] out_valid,
  input wire logic [NUM_PATHS-1:0][63:0] out_tag,
  input wire logic [NUM_PATHS-1:0] out_detect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic req;
  assign req = av_req.read | av_req.write;
  // ========
  // register bus
  chk_wait_one: assert property (req && av_rsp.waitrequest |=> !av_rsp.waitrequest)
    else $error("request not answered after one wait state");
  chk_wait_pulse: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("answer longer than one cycle");
  chk_wait_idle: assert property (!req && av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("answer without request");
  chk_unmapped_zero: assert property (av_req.read && av_req.address[7] && av_rsp.waitrequest
    |=> av_rsp.readdata == '0) else $error("unmapped read not zero");
  chk_write_zero: assert property (av_req.write && av_rsp.waitrequest
    |=> av_rsp.readdata == '0) else $error("write answer carries data");
  // ========
  // reset and outputs
  chk_reset_state: assert property ($fell(srst) |-> uart_tx == 2'b11
    && av_rsp.waitrequest && out_valid == '0) else $error("bad state after reset");
  chk_tag_hold: assert property (out_valid == '0 |-> $stable(out_tag))
    else $error("tag moved without a dump");
  chk_detect_hold: assert property (out_valid == '0 |-> $stable(out_detect))
    else $error("detect moved without a dump");
  chk_sample_hold: assert property (out_valid == '0 |-> $stable(out_sample))
    else $error("sample moved without a dump");
endmodule : receiver_checker
bind receiver_control_tuner_cic receiver_checker receiver_checker_i (.clk(clk), .srst(srst),
  .av_req(av_req), .av_rsp(av_rsp), .uart_tx(uart_tx), .out_sample(out_sample),
  .out_valid(out_valid), .out_tag(out_tag), .out_detect(out_detect));
`default_nettype wire

// file: verification/mcs_serial_model.sv
// Purpose: monitor-and-control computer on one serial port
// Assumes: 8N1, one bit lasts BAUD clk cycles
// Notes: frame keeps the 26 bytes after the last sync byte
`default_nettype none
module mcs_serial_model
  import receiver_pkg::*;
#(
  parameter int BAUD = 4
) (
  input wire logic clk,
  output var logic line_out,
  input wire logic line_in
);
  logic [7:0] frame [26];
  int frames = 0;
  initial line_out = 1'b1;
  // ========
  // commands: address byte then data little endian
  task automatic send_cmd(input logic [7:0] a, input logic [31:0] d);
    logic [39:0] w;
    w = {d, a};
    for (int b = 0; b < 5; b++) begin
      for (int k = 0; k < 10; k++) begin
        line_out <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : w[8 * b + k - 1];
        repeat (BAUD) @(posedge clk);
      end
    end
  endtask : send_cmd
  // ========
  // telemetry receiver, sampled mid bit
  initial begin
    logic [7:0] b;
    int n;
    n = 0;
    wait (line_in === 1'b1);
    forever begin
      @(negedge line_in);
      repeat (BAUD / 2) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        repeat (BAUD) @(posedge clk);
        b[k] = line_in;
      end
      repeat (BAUD) @(posedge clk);
      if (n == 0) begin
        n = (b == FRAME_SYNC) ? 1 : 0;
      end else begin
        frame[n - 1] = b;
        n = (n == 26) ? 0 : n + 1;
        if (n == 0) frames++;
      end
    end
  end
endmodule : mcs_serial_model
`default_nettype wire

// file: verification/tb_receiver_control_tuner_cic.sv
// Purpose: self-checking bench of the receiver control, tuner and CIC block
// Assumes: bit time shortened to 4 clk; only the polarization 1 marker toggles
// Notes: only path 0 polarization clock monitor toggles
`default_nettype none
module tb_receiver_control_tuner_cic
  import receiver_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] TAG = 64'h0123_4567_89AB_CDEF;
  logic clk = 1'b0;
  logic srst = 1'b1;
  av_req_t av_req = '0;
  av_rsp_t av_rsp;
  lanes_t [NUM_POL-1:0] lanes;
  logic [NUM_POL-1:0] bu_valid = '0;
  logic [NUM_POL-1:0] clk_mon = '0;
  logic [NUM_POL-1:0] marker = '0;
  logic epoch = 1'b0;
  logic [NUM_POL-1:0] rx, tx;
  logic [NUM_PATHS-1:0][1:0][CIC_W-1:0] out_sample;
  logic [NUM_PATHS-1:0] out_valid, out_detect;
  logic [NUM_PATHS-1:0][63:0] out_tag;
  int err_total = 0, n_tests = 0, cyc = 0, n_feed = 0, ph = 0, f;
  int cnt [NUM_PATHS] = '{default: 0};
  logic [31:0] q;
  logic [207:0] snap;
  cfg_t e1;
  always #25 clk = ~clk;
  receiver_control_tuner_cic #(.BAUD_CYC(8'h04)) receiver_control_tuner_cic_i (.clk(clk),
    .srst(srst), .av_req(av_req), .av_rsp(av_rsp), .beamforming_unit_lanes(lanes),
    .beamforming_unit_valid(bu_valid), .beamforming_unit_clk_mon(clk_mon),
    .beamforming_unit_marker(marker), .epoch_pulse(epoch), .uart_rx(rx), .uart_tx(tx),
    .out_sample(out_sample), .out_valid(out_valid), .out_tag(out_tag),
    .out_detect(out_detect));
  mcs_serial_model #(.BAUD(4)) mcs_serial_model_i0 (.clk(clk), .line_out(rx[0]),
    .line_in(tx[0]));
  mcs_serial_model #(.BAUD(4)) mcs_serial_model_i1 (.clk(clk), .line_out(rx[1]),
    .line_in(tx[1]));
  // ========
  // compare and bus tasks
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_vec(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    av_req <= '{read: !w, write: w, address: a, writedata: d};
    do @(posedge clk); while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata;
    av_req <= '0;
    @(posedge clk);
  endtask : av
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    av(1'b0, a, '0);
    chk_reg(nm, e, q);
  endtask : rd
  task test_done;
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // ========
  // sample feed, dump counting, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clk_mon[0] <= ~clk_mon[0];
    marker[1] <= ~marker[1];
    bu_valid <= (n_feed != 0 && ph == 0) ? 2'b11 : 2'b00;
    if (n_feed != 0) begin
      ph <= (ph + 1) % 4;
      if (ph == 3) n_feed <= n_feed - 1;
    end
    for (int p = 0; p < NUM_PATHS; p++) if (out_valid[p] === 1'b1) cnt[p] <= cnt[p] + 1;
    if (cyc == 30000) begin
      err_total++;
      test_done();
    end
  end
  // ========
  // main sequence
  initial begin
    // lane counts stay constant, so both test modes must raise their error flags
    for (int p = 0; p < NUM_POL; p++)
      for (int l = 0; l < NUM_LANES; l++)
        lanes[p][l] <= '{p ? 4'h2 : 4'h4, 12'h100, 12'h0F0};
    e1 = '{1'b1, 3'h5, 10'h3FF, 12'hFFF, TAG};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    n_feed <= 8;
    rd(8'h20, 32'h0, "pending ctrl at reset");
    av(1'b1, 8'h20, 32'h03FF_0051);
    av(1'b1, 8'h24, 32'h0000_0FFF);
    av(1'b1, 8'h28, TAG[31:0]);
    av(1'b1, 8'h2C, TAG[63:32]);
    av(1'b1, 8'h30, 32'hFFFF_FFFF);
    av(1'b1, 8'h80, 32'hFFFF_FFFF);
    mcs_serial_model_i1.send_cmd(8'h00, 32'h0155_0001);
    rd(8'h20, 32'h03FF_0051, "pending ctrl");
    rd(8'h2C, TAG[63:32], "pending tag high");
    rd(8'h40, 32'h0155_0001, "serial pending ctrl");
    rd(8'h30, 32'h0, "active ctrl before epoch");
    rd(8'h80, 32'h0, "unmapped read");
    epoch <= 1'b1;
    repeat (3) @(posedge clk);
    epoch <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h30, 32'h03FF_0051, "active ctrl");
    rd(8'h34, 32'h0000_0FFF, "active accum");
    rd(8'h50, 32'h0155_0001, "active serial ctrl");
    rd(8'h38, 32'h0000_0791, "status");
    rd(8'h58, 32'h0000_004A, "status pol 1");
    f = mcs_serial_model_i0.frames;
    wait (mcs_serial_model_i0.frames >= f + 2);
    for (int k = 0; k < 26; k++) snap[8 * k +: 8] = mcs_serial_model_i0.frame[k];
    chk_vec("telemetry path 1 settings", 128'(e1), 128'(snap[193:104]));
    chk_vec("telemetry path 0 settings", 128'h0, 128'(snap[89:0]));
    chk_vec("telemetry status", 128'h48F, 128'(snap[204:194]));
    f = mcs_serial_model_i1.frames;
    wait (mcs_serial_model_i1.frames > f);
    for (int k = 0; k < 26; k++) snap[8 * k +: 8] = mcs_serial_model_i1.frame[k];
    e1 = '{1'b1, 3'h0, 10'h155, 12'h000, 64'h0};
    chk_vec("telemetry path 2 settings", 128'(e1), 128'(snap[89:0]));
    chk_vec("telemetry path 2 status", 128'h250, 128'(snap[100:90]));
    n_feed <= 128;
    @(posedge clk);
    wait (n_feed == 0);
    repeat (20) @(posedge clk);
    chk_vec("dumps path 1", 128'h2, 128'(cnt[1]));
    chk_vec("dumps path 2", 128'h40, 128'(cnt[2]));
    chk_vec("dumps disabled paths", 128'h0, 128'(cnt[0] + cnt[3]));
    chk_vec("tag path 1", 128'(TAG), 128'(out_tag[1]));
    chk_vec("detect", 128'h2, 128'(out_detect));
    test_done();
  end
endmodule : tb_receiver_control_tuner_cic
`default_nettype wire
